// >>> verilog/rsp_port.sv
// serial register port slave with mode-driven block enables
`timescale 1ns/1ps
// Functional notes
// - each access is sixteen serial clocks within one select-low period
// - field order: direction bit, seven address bits, eight data bits
// - seven-bit address picks one of 128 eight-bit registers
// - direction 1 writes, direction 0 reads
// - address and data bytes are captured after each eight clocks
// - input data during a read data field is ignored
// - read data shifts out on the eight falling edges after address
// - output holds last data bit until select rises
// - select high releases output; pull-up holds it high
// - burst: held select and more clocks advance to next register
// - burst takes a further byte every eight clocks, no address resent
// - every mode, shutdown included, is selectable on i_mode_sel
// - shutdown powers everything down and loses register contents; rsp_regmem has no reset or shutdown input and keeps them
// - each mode applies its fixed block enable pattern
// - don't-care blocks follow independent enable controls
module rsp_port
    import rsp_pkg::*;
(
    input  wire logic       i_mclk,
    input  wire logic       i_sys_rst,
    input  wire logic       i_shutdown,
    input  wire logic [2:0] i_mode_sel,
    input  wire logic       i_osc32_opt,
    input  wire logic       i_aux_opt,
    input  wire logic       i_sclk,
    input  wire logic       i_port_select_n,
    input  wire logic       i_serial_in,
    output logic            o_serial_out,
    output logic            o_serial_out_oe_n,
    output logic [7:0]      o_block_en,
    output logic            o_wr_strobe,
    output logic [6:0]      o_wr_addr,
    output logic [7:0]      o_wr_data
);
    typedef struct packed {
        logic       sclk_d;
        logic       sel_n_d;
        rsp_state_e st;
        logic [2:0] bit_cnt;
        logic [7:0] shift_in;
        logic       is_write;
        logic [6:0] addr;
        logic [7:0] shift_out;
        logic       load_pend;
        logic       sout;
        logic       sout_oe_n;
        logic [7:0] block_en;
        logic       wr_stb;
        logic [6:0] wr_addr;
        logic [7:0] wr_data;
    } rsp_state_s;

    rsp_state_s st_r;
    rsp_state_s st_nxt;
    logic [7:0] mem_rd_data;
    logic       mem_wr_en;

    // fixed enable pattern per mode; don't-care cells follow the option pins
    function automatic logic [7:0] mode_enables(input logic [2:0] m, input logic o32, input logic aux);
        logic [7:0] e;
        e = RSP_EN_RST;
        case (m)
            RSP_MODE_SHUTDOWN: begin
                e = RSP_EN_RST;
            end

            RSP_MODE_STANDBY: begin
                e[RSP_EN_LDO]   = 1'b1;
                e[RSP_EN_SPI]   = 1'b1;
                e[RSP_EN_OSC32] = 1'b0;
                e[RSP_EN_AUX]   = 1'b0;
                e[RSP_EN_XTAL]  = 1'b0;
                e[RSP_EN_PLL]   = 1'b0;
                e[RSP_EN_PA]    = 1'b0;
                e[RSP_EN_RX]    = 1'b0;
            end

            RSP_MODE_SLEEP: begin
                e[RSP_EN_LDO]   = 1'b1;
                e[RSP_EN_SPI]   = 1'b1;
                e[RSP_EN_OSC32] = 1'b1;
                e[RSP_EN_AUX]   = aux;
                e[RSP_EN_XTAL]  = 1'b0;
                e[RSP_EN_PLL]   = 1'b0;
                e[RSP_EN_PA]    = 1'b0;
                e[RSP_EN_RX]    = 1'b0;
            end

            RSP_MODE_SENSOR: begin
                e[RSP_EN_LDO]   = 1'b1;
                e[RSP_EN_SPI]   = 1'b1;
                e[RSP_EN_OSC32] = o32;
                e[RSP_EN_AUX]   = 1'b1;
                e[RSP_EN_XTAL]  = 1'b0;
                e[RSP_EN_PLL]   = 1'b0;
                e[RSP_EN_PA]    = 1'b0;
                e[RSP_EN_RX]    = 1'b0;
            end

            RSP_MODE_READY: begin
                e[RSP_EN_LDO]   = 1'b1;
                e[RSP_EN_SPI]   = 1'b1;
                e[RSP_EN_OSC32] = o32;
                e[RSP_EN_AUX]   = aux;
                e[RSP_EN_XTAL]  = 1'b1;
                e[RSP_EN_PLL]   = 1'b0;
                e[RSP_EN_PA]    = 1'b0;
                e[RSP_EN_RX]    = 1'b0;
            end

            RSP_MODE_TUNING: begin
                e[RSP_EN_LDO]   = 1'b1;
                e[RSP_EN_SPI]   = 1'b1;
                e[RSP_EN_OSC32] = o32;
                e[RSP_EN_AUX]   = aux;
                e[RSP_EN_XTAL]  = 1'b1;
                e[RSP_EN_PLL]   = 1'b1;
                e[RSP_EN_PA]    = 1'b0;
                e[RSP_EN_RX]    = 1'b0;
            end

            RSP_MODE_TRANSMIT: begin
                e[RSP_EN_LDO]   = 1'b1;
                e[RSP_EN_SPI]   = 1'b1;
                e[RSP_EN_OSC32] = o32;
                e[RSP_EN_AUX]   = aux;
                e[RSP_EN_XTAL]  = 1'b1;
                e[RSP_EN_PLL]   = 1'b1;
                e[RSP_EN_PA]    = 1'b1;
                e[RSP_EN_RX]    = 1'b0;
            end

            RSP_MODE_RECEIVE: begin
                e[RSP_EN_LDO]   = 1'b1;
                e[RSP_EN_SPI]   = 1'b1;
                e[RSP_EN_OSC32] = o32;
                e[RSP_EN_AUX]   = aux;
                e[RSP_EN_XTAL]  = 1'b1;
                e[RSP_EN_PLL]   = 1'b1;
                e[RSP_EN_PA]    = 1'b0;
                e[RSP_EN_RX]    = 1'b1;
            end

            default: begin
                e = RSP_EN_RST;
            end
        endcase
        return e;
    endfunction

    // edge detectors on the host clock, sampled by the system clock
    function automatic logic edge_rise(input logic now, input logic prev);
        return now & ~prev;
    endfunction

    function automatic logic edge_fall(input logic now, input logic prev);
        return ~now & prev;
    endfunction

    // msb-first shifter shared by address and data bytes
    function automatic logic [7:0] shift_msb_in(input logic [7:0] sr, input logic b);
        return {sr[6:0], b};
    endfunction

    // last bit is refilled so the line keeps it after the eighth fall
    function automatic logic [7:0] shift_hold_out(input logic [7:0] sr);
        return {sr[6:0], sr[0]};
    endfunction

    function automatic logic in_read_field(input rsp_state_e s, input logic wr);
        return (s == RSP_ST_DATA) && !wr;
    endfunction

    assign mem_wr_en = st_nxt.wr_stb;

    // read address from next state, so data is ready by the load edge
    rsp_regmem u_regmem (
        .i_mclk    (i_mclk),
        .i_wr_en   (mem_wr_en),
        .i_wr_addr (st_nxt.wr_addr),
        .i_wr_data (st_nxt.wr_data),
        .i_rd_addr (st_nxt.addr),
        .o_rd_data (mem_rd_data)
    );

    always_comb begin
        logic       rise;
        logic       fall;
        logic [7:0] byte_in;

        rise    = 1'b0;
        fall    = 1'b0;
        byte_in = RSP_REG_RST;
        st_nxt  = st_r;
        st_nxt.sclk_d   = i_sclk;
        st_nxt.sel_n_d  = i_port_select_n;
        st_nxt.wr_stb   = 1'b0;
        st_nxt.block_en = mode_enables(i_shutdown ? RSP_MODE_SHUTDOWN : i_mode_sel, i_osc32_opt, i_aux_opt);

        rise    = edge_rise(i_sclk, st_r.sclk_d);
        fall    = edge_fall(i_sclk, st_r.sclk_d);
        byte_in = shift_msb_in(st_r.shift_in, i_serial_in);

        // register read data arrives a cycle after the address is known
        if (st_r.load_pend) begin
            st_nxt.shift_out = mem_rd_data;
            st_nxt.load_pend = 1'b0;
        end

        // shutdown and select high both force the idle frame state
        if (i_shutdown || i_port_select_n) begin
            st_nxt.st        = RSP_ST_IDLE;
            st_nxt.bit_cnt   = RSP_BIT_RST;
            st_nxt.sout      = 1'b1;
            st_nxt.sout_oe_n = 1'b1;
            st_nxt.load_pend = 1'b0;
        end else begin
            // fresh frame starts from a clean shifter, no stale direction
            if (st_r.sel_n_d) begin
                st_nxt.shift_in = RSP_REG_RST;
                st_nxt.is_write = 1'b0;
            end
            if (st_r.st == RSP_ST_IDLE) begin
                st_nxt.st = RSP_ST_ADDR;
            end

            if (rise) begin
                st_nxt.shift_in = byte_in;
                st_nxt.bit_cnt  = st_r.bit_cnt + 3'h1;
                if (st_r.bit_cnt == RSP_BYTE_LAST) begin
                    case (st_r.st)
                        RSP_ST_IDLE, RSP_ST_ADDR: begin
                            st_nxt.is_write  = byte_in[7];
                            st_nxt.addr      = byte_in[6:0];
                            st_nxt.st        = RSP_ST_DATA;
                            st_nxt.load_pend = ~byte_in[7];
                        end
                        RSP_ST_DATA: begin
                            if (st_r.is_write) begin
                                st_nxt.wr_stb  = 1'b1;
                                st_nxt.wr_addr = st_r.addr;
                                st_nxt.wr_data = byte_in;
                            end
                            // read data bits are dropped here
                            // address wraps from 127 to 0 in a long burst
                            st_nxt.addr      = st_r.addr + 7'h01;
                            st_nxt.load_pend = ~st_r.is_write;
                        end
                        default: begin
                            st_nxt.st = RSP_ST_IDLE;
                        end
                    endcase
                end
            end

            // read byte leaves msb first on falling edges of the data field
            if (fall && in_read_field(st_r.st, st_r.is_write)) begin
                st_nxt.sout      = st_r.shift_out[7];
                st_nxt.sout_oe_n = 1'b0;
                st_nxt.shift_out = shift_hold_out(st_r.shift_out);
            end
        end

        // reset wins over every frame event
        if (i_sys_rst) begin
            st_nxt.sclk_d    = 1'b0;
            st_nxt.sel_n_d   = 1'b1;
            st_nxt.st        = RSP_ST_IDLE;
            st_nxt.bit_cnt   = RSP_BIT_RST;
            st_nxt.shift_in  = RSP_REG_RST;
            st_nxt.is_write  = 1'b0;
            st_nxt.addr      = RSP_ADDR_RST;
            st_nxt.shift_out = RSP_REG_RST;
            st_nxt.load_pend = 1'b0;
            st_nxt.sout      = 1'b1;
            st_nxt.sout_oe_n = 1'b1;
            st_nxt.block_en  = RSP_EN_RST;
            st_nxt.wr_stb    = 1'b0;
            st_nxt.wr_addr   = RSP_ADDR_RST;
            st_nxt.wr_data   = RSP_REG_RST;
        end
    end

    // one register stage for all state; outputs come straight from it
    always_ff @(posedge i_mclk) begin
        st_r <= st_nxt;
    end

    assign o_serial_out      = st_r.sout;
    assign o_serial_out_oe_n = st_r.sout_oe_n;
    assign o_block_en        = st_r.block_en;
    assign o_wr_strobe       = st_r.wr_stb;
    assign o_wr_addr         = st_r.wr_addr;
    assign o_wr_data         = st_r.wr_data;
endmodule

// >>> include/rsp_pkg.sv
// package of constants and types for the radio serial register port
package rsp_pkg;
    localparam int          RSP_FRAME_BITS = 16;
    localparam int          RSP_ADDR_W     = 7;
    localparam int          RSP_DATA_W     = 8;
    localparam int          RSP_REG_COUNT  = 128;
    localparam logic [2:0]  RSP_BYTE_LAST  = 3'h7;
    localparam logic [2:0]  RSP_BIT_RST    = 3'h0;
    localparam logic [7:0]  RSP_REG_RST    = 8'h00;
    localparam logic [6:0]  RSP_ADDR_RST   = 7'h00;
    // enable vector bit positions
    localparam int          RSP_EN_LDO     = 0;
    localparam int          RSP_EN_SPI     = 1;
    localparam int          RSP_EN_OSC32   = 2;
    localparam int          RSP_EN_AUX     = 3;
    localparam int          RSP_EN_XTAL    = 4;
    localparam int          RSP_EN_PLL     = 5;
    localparam int          RSP_EN_PA      = 6;
    localparam int          RSP_EN_RX      = 7;
    localparam logic [7:0]  RSP_EN_RST     = 8'h00;

    typedef enum logic [2:0] {
        RSP_MODE_SHUTDOWN = 3'h0,
        RSP_MODE_STANDBY  = 3'h1,
        RSP_MODE_SLEEP    = 3'h3,
        RSP_MODE_SENSOR   = 3'h2,
        RSP_MODE_READY    = 3'h6,
        RSP_MODE_TUNING   = 3'h7,
        RSP_MODE_TRANSMIT = 3'h5,
        RSP_MODE_RECEIVE  = 3'h4
    } rsp_mode_e;

    // frame phase, gray along idle -> address -> data
    typedef enum logic [1:0] {
        RSP_ST_IDLE = 2'h0,
        RSP_ST_ADDR = 2'h1,
        RSP_ST_DATA = 2'h3
    } rsp_state_e;
endpackage

// >>> verilog/rsp_regmem.sv
// 128 x 8 register space with registered read data
`timescale 1ns/1ps
module rsp_regmem
    import rsp_pkg::*;
(
    input  wire logic       i_mclk,
    input  wire logic       i_wr_en,
    input  wire logic [6:0] i_wr_addr,
    input  wire logic [7:0] i_wr_data,
    input  wire logic [6:0] i_rd_addr,
    output logic      [7:0] o_rd_data
);
    logic [7:0] mem_r [0:RSP_REG_COUNT-1];

    // no reset: contents only matter after a write, as after shutdown
    always_ff @(posedge i_mclk) begin
        if (i_wr_en) begin
            mem_r[i_wr_addr] <= i_wr_data;
        end
        o_rd_data <= mem_r[i_rd_addr];
    end
endmodule

// >>> test/rsp_host_model.sv
// host-side serial master model
`timescale 1ns/1ps
module rsp_host_model (
    input  wire logic i_mclk,
    input  wire logic i_line,
    output logic      o_sclk,
    output logic      o_sel_n,
    output logic      o_sdi
);
    localparam int HALF = 13; // 104 ns period keeps clock under 10 MHz
    initial begin
        o_sclk = 1'b0;
        o_sel_n = 1'b1;
        o_sdi = 1'b1;
    end
    // data changes on fall, msb first, n bits of tx
    task automatic bits(input logic [7:0] tx, input int n, output logic [7:0] rx);
        rx = 8'h00;
        for (int b = 7; b > 7 - n; b--) begin
            o_sclk = 1'b0;
            o_sdi = tx[b];
            repeat (HALF) @(posedge i_mclk);
            #1 rx[b] = i_line;
            o_sclk = 1'b1;
            repeat (HALF) @(posedge i_mclk);
            #1;
        end
    endtask
    task automatic sel(input logic v);
        repeat (HALF) @(posedge i_mclk);
        #1 o_sel_n = v;
        o_sdi = v ? !o_sdi : o_sdi;
        repeat (HALF) @(posedge i_mclk);
        #1 o_sclk = 1'b0; // clock rests low outside frames
    endtask
endmodule

// >>> test/rsp_port_properties.sv
// assertions for the serial register port
`timescale 1ns/1ps
module rsp_port_chk
    import rsp_pkg::*;
(
    input wire logic       i_mclk,
    input wire logic       i_sys_rst,
    input wire logic       i_shutdown,
    input wire logic [2:0] i_mode_sel,
    input wire logic       i_sclk,
    input wire logic       i_port_select_n,
    input wire logic       i_serial_in,
    input wire logic       o_serial_out,
    input wire logic       o_serial_out_oe_n,
    input wire logic [7:0] o_block_en,
    input wire logic       o_wr_strobe,
    input wire logic [6:0] o_wr_addr,
    input wire logic [7:0] o_wr_data
);
    logic       sclk_r;
    logic       dir_r;
    logic [7:0] cnt_r;
    logic [7:0] sh_r;
    logic [7:0] hdr_r;
    // shadow decoder; select high drops any partial count
    always_ff @(posedge i_mclk) begin
        sclk_r <= i_sclk;
        if (i_sys_rst || i_port_select_n) begin
            cnt_r <= 8'h00;
        end else if (i_sclk && !sclk_r) begin
            cnt_r <= cnt_r + 8'h01;
            sh_r <= {sh_r[6:0], i_serial_in};
            dir_r <= (cnt_r == 8'h00) ? i_serial_in : dir_r;
            hdr_r <= (cnt_r == 8'h07) ? {sh_r[6:0], i_serial_in} : hdr_r;
        end
    end
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (i_sys_rst);
    sequence released_s;
        i_port_select_n ##1 i_port_select_n;
    endsequence
    sequence powered_s;
        !i_shutdown && i_mode_sel != RSP_MODE_SHUTDOWN ##1 !i_shutdown && i_mode_sel != RSP_MODE_SHUTDOWN;
    endsequence
    chk_release_idle: assert property (released_s |-> o_serial_out_oe_n && o_serial_out)
        else $error("output not released");
    chk_strobe_pulse: assert property (o_wr_strobe |=> !o_wr_strobe)
        else $error("strobe too long");
    chk_byte_boundary: assert property (o_wr_strobe |-> cnt_r >= 8'h10 && cnt_r[2:0] == 3'h0)
        else $error("strobe off a byte boundary");
    chk_write_dir: assert property (o_wr_strobe |-> dir_r)
        else $error("strobe on read");
    chk_write_data: assert property (o_wr_strobe |-> o_wr_data == sh_r)
        else $error("bad write data");
    chk_write_addr: assert property (o_wr_strobe |-> o_wr_addr == 7'(hdr_r[6:0] + cnt_r[7:3] - 8'h02))
        else $error("bad write address");
    chk_read_drive: assert property (!o_serial_out_oe_n |-> !dir_r)
        else $error("driven on write");
    chk_shutdown_off: assert property (i_shutdown |=> o_block_en == RSP_EN_RST && !o_wr_strobe)
        else $error("active in shutdown");
    chk_mode_base: assert property (powered_s |-> o_block_en[RSP_EN_LDO] && o_block_en[RSP_EN_SPI])
        else $error("base blocks off");
endmodule
bind rsp_port rsp_port_chk rsp_port_chk_i (.i_mclk(i_mclk), .i_sys_rst(i_sys_rst), .i_shutdown(i_shutdown),
    .i_mode_sel(i_mode_sel),
    .i_sclk(i_sclk), .i_port_select_n(i_port_select_n), .i_serial_in(i_serial_in), .o_serial_out(o_serial_out),
    .o_serial_out_oe_n(o_serial_out_oe_n), .o_block_en(o_block_en), .o_wr_strobe(o_wr_strobe),
    .o_wr_addr(o_wr_addr), .o_wr_data(o_wr_data));

// >>> test/tb_top.sv
// self-checking bench for the serial register port
`timescale 1ns/1ps
module tb_top;
    import rsp_pkg::*;
    logic       clk, rst, sd, osc, aux, sclk, sel_n, serial_in, sout, oe_n, stb, line;
    logic [2:0] mode;
    logic [6:0] waddr;
    logic [7:0] en, wdata, rx;
    int         miscompares, cmp_count, stbs;
    logic [7:0] frm [6][3] = '{'{8'h80, 8'h5A, 8'h00}, '{8'hFF, 8'hC3, 8'h00}, '{8'h92, 8'h85, 8'h00},
                              '{8'h00, 8'hFF, 8'h5A}, '{8'h7F, 8'h00, 8'hC3}, '{8'h12, 8'hA5, 8'h85}};
    logic [7:0] mtab [8][3] = '{'{8'h01, 8'h03, 8'h00}, '{8'h03, 8'h07, 8'h08}, '{8'h02, 8'h0B, 8'h04},
                               '{8'h06, 8'h13, 8'h0C}, '{8'h07, 8'h33, 8'h0C}, '{8'h05, 8'h73, 8'h0C},
                               '{8'h04, 8'hB3, 8'h0C}, '{8'h00, 8'h00, 8'h00}};
    assign line = oe_n ? 1'b1 : sout; // pull-up holds a released line high
    rsp_host_model host_i (.i_mclk(clk), .i_line(line), .o_sclk(sclk), .o_sel_n(sel_n), .o_sdi(serial_in));
    rsp_port rsp_port_i (.i_mclk(clk), .i_sys_rst(rst), .i_shutdown(sd), .i_mode_sel(mode), .i_osc32_opt(osc),
        .i_aux_opt(aux), .i_sclk(sclk), .i_port_select_n(sel_n), .i_serial_in(serial_in), .o_serial_out(sout),
        .o_serial_out_oe_n(oe_n), .o_block_en(en), .o_wr_strobe(stb), .o_wr_addr(waddr), .o_wr_data(wdata));
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    always @(posedge clk) if (stb === 1'b1) stbs++;
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            miscompares++;
            $display("wrong value at %0t: %h vs %h", $time, seen, exp);
        end
    endtask
    task automatic conclude;
        if (miscompares == 0 && cmp_count > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    // one frame of n data bytes; reads expect e0 upward, writes d0 upward
    task automatic xfer(input logic [7:0] hdr, input logic [7:0] d0, input logic [7:0] e0, input int n);
        int s0;
        s0 = stbs;
        host_i.sel(1'b0);
        host_i.bits(hdr, 8, rx);
        for (int k = 0; k < n; k++) begin
            host_i.bits(d0 + 8'(k), 8, rx);
            if (hdr[7]) begin
                chk({1'b0, waddr}, {1'b0, 7'(hdr + 8'(k))});
                chk(wdata, d0 + 8'(k));
            end else chk(rx, e0 + 8'(k));
        end
        if (!hdr[7]) chk({7'h0, sout}, {7'h0, rx[0]});
        host_i.sel(1'b1);
        chk({6'h0, oe_n, sout}, 8'h03);
        chk(8'(stbs - s0), hdr[7] ? 8'(n) : 8'h00);
    endtask
    initial begin
        rst = 1'b1;
        sd = 1'b0;
        osc = 1'b0;
        aux = 1'b0;
        mode = RSP_MODE_READY;
        repeat (6) @(posedge clk);
        #1 rst = 1'b0;
        foreach (mtab[i]) for (int o = 0; o < 4; o++) begin
            mode = mtab[i][0][2:0];
            {aux, osc} = 2'(o);
            repeat (2) @(posedge clk);
            #1 chk(en, mtab[i][1] | (mtab[i][2] & {4'h0, aux, osc, 2'h0}));
        end
        mode = RSP_MODE_READY;
        foreach (frm[i]) xfer(frm[i][0], frm[i][1], frm[i][2], 1);
        xfer(8'hFE, 8'h10, 8'h00, 3);
        xfer(8'h7E, 8'hF0, 8'h10, 3);
        host_i.sel(1'b0);
        host_i.bits(8'hFF, 5, rx);
        host_i.sel(1'b1);
        xfer(8'h92, 8'h33, 8'h00, 1);
        sd = 1'b1;
        host_i.sel(1'b0);
        host_i.bits(8'h85, 8, rx);
        host_i.bits(8'h77, 8, rx);
        host_i.sel(1'b1);
        chk(en, RSP_EN_RST);
        chk(wdata, 8'h33);
        sd = 1'b0;
        rst = 1'b1;
        repeat (2) @(posedge clk);
        #1 chk({waddr, oe_n}, 8'h01);
        chk(wdata, 8'h00);
        rst = 1'b0;
        conclude;
    end
    initial begin
        repeat (50000) @(posedge clk);
        miscompares++;
        conclude;
    end
endmodule
